/* core/sahi_pkg.sv */
// Shared constants and types of the converter host interface
package sahi_pkg;

   // ==========================================================
   // Widths
   localparam int RES_W      = 10;
   localparam int BYTE_W     = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int SYNC_W     = 9;

   // ==========================================================
   // Timing
   localparam int CLK_HZ         = 100_000_000;
   localparam int SAMPLE_TIME_NS = 10_000;
   localparam int SAMPLE_CYC     = (SAMPLE_TIME_NS / 1000) * (CLK_HZ / 1_000_000);
   localparam int OSC_NORMAL_HZ  = 250_000;
   localparam int OSC_FAST_HZ    = 500_000;
   localparam int OSC_NORMAL_CYC = CLK_HZ / OSC_NORMAL_HZ;
   localparam int OSC_FAST_CYC   = CLK_HZ / OSC_FAST_HZ;
   localparam int MAX_RATE_SPS   = 25_000;
   localparam int MIN_CONV_CYC   = CLK_HZ / MAX_RATE_SPS;

   // ==========================================================
   // Positions in the synchroniser vector
   localparam int SY_WFS  = 0;
   localparam int SY_BHS  = 1;
   localparam int SY_CSL  = 2;
   localparam int SY_CE   = 3;
   localparam int SY_RDC  = 4;
   localparam int SY_XCK  = 5;
   localparam int SY_FRQ  = 6;
   localparam int SY_SCK  = 7;
   localparam int SY_CMP  = 8;

   // ==========================================================
   // Reset values and the first trial code
   localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
   localparam logic [RES_W-1:0] OE_ALL_OFF = 10'h3ff;
   localparam logic [RES_W-1:0] MSB_ONLY   = 10'h200;

   typedef enum logic [1:0] {
      SAHI_IDLE    = 2'b00,
      SAHI_SAMPLE  = 2'b01,
      SAHI_CONVERT = 2'b10,
      SAHI_STORE   = 2'b11
   } sahi_state_t;

   // Parallel word: full word, high byte on D9..D2, or low bits with zeros on D7..D2
   function automatic logic [RES_W-1:0] sahi_par_word(input logic [RES_W-1:0] r,
                                                      input logic wfs,
                                                      input logic bhs);
      if (wfs)
         return r;
      else if (!bhs)
         return {r[9:2], 2'b00};
      else
         return {2'b00, 6'h00, r[1:0]};
   endfunction

   // Per-pin output enable (low = driving)
   function automatic logic [RES_W-1:0] sahi_par_oe_n(input logic wfs, input logic bhs);
      if (wfs)
         return 10'h000;
      else if (!bhs)
         return 10'h003;
      else
         return 10'h300;
   endfunction

endpackage

/* core/sahi_fifo_if.sv */
// Handshake carrier between the converter core and its result FIFO
`timescale 1ns/1ps
`default_nettype none
interface sahi_fifo_if #(parameter int W = 10);
   logic [W-1:0] wdata;
   logic         wvalid;
   logic         wready;
   logic [W-1:0] rdata;
   logic         rvalid;
   logic         rready;

   modport fill  (output wdata, output wvalid, input wready);
   modport drain (input rdata, input rvalid, output rready);
   modport fifo  (input wdata, input wvalid, input rready,
                  output wready, output rdata, output rvalid);
endinterface
`default_nettype wire

/* core/sahi_fifo.sv */
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sahi_fifo #(
   parameter int W     = 10,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   sahi_fifo_if.fifo f
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      return (p == LAST) ? '0 : p + 1'b1;
   endfunction

   assign f.wready = (cnt_q != (AW+1)'(DEPTH));
   assign f.rvalid = (cnt_q != '0);
   assign f.rdata  = mem_q[rd_q];
   assign push     = f.wvalid && f.wready;
   assign pop      = f.rvalid && f.rready;

   // ==========================================================
   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= f.wdata;
      end
   end

   // ==========================================================
   // Pointers and fill level
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= nxt(wr_q);
         end
         if (pop) begin
            rd_q <= nxt(rd_q);
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* core/sahi_top.sv */
// Control and readout logic of the 10-bit successive approximation converter
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module sahi_top
   import sahi_pkg::*;
#(
   parameter int RW    = RES_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          word_format_select,
   input  wire logic          byte_half_select,
   input  wire logic          chip_select_low,
   input  wire logic          chip_enable,
   input  wire logic          read_convert_select,
   input  wire logic          ext_conversion_clock,
   input  wire logic          freq_ctrl,
   input  wire logic          shift_clock,
   input  wire logic          comparator_above,
   output logic [RW-1:0]      dac_code,
   output logic               sample_active,
   output logic [RW-1:0]      parallel_result_bus,
   output logic [RW-1:0]      parallel_oe_n,
   output logic               serial_out,
   output logic               serial_oe_n,
   output logic               conversion_done_low,
   output logic               start_refused
);
   // ==========================================================
   // Input synchronisers
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic              xck_prev_q;
   logic              sck_prev_q;
   logic              wsel_prev_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Both stages idle deselected, so no driven glitch follows reset
         sync1_q <= 9'h004;
         sync2_q <= 9'h004;
      end else begin
         sync1_q <= {comparator_above, shift_clock, freq_ctrl, ext_conversion_clock,
                     read_convert_select, chip_enable, chip_select_low,
                     byte_half_select, word_format_select};
         sync2_q <= sync1_q;
      end
   end

   logic selected;
   logic read_sel;
   logic write_sel;
   logic xck_rise;
   logic sck_fall;

   assign selected  = !sync2_q[SY_CSL] && sync2_q[SY_CE];
   assign read_sel  = selected && sync2_q[SY_RDC];
   assign write_sel = selected && !sync2_q[SY_RDC];
   assign xck_rise  = sync2_q[SY_XCK] && !xck_prev_q;
   assign sck_fall  = !sync2_q[SY_SCK] && sck_prev_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         xck_prev_q  <= 1'b0;
         sck_prev_q  <= 1'b0;
         wsel_prev_q <= 1'b0;
      end else begin
         xck_prev_q  <= sync2_q[SY_XCK];
         sck_prev_q  <= sync2_q[SY_SCK];
         wsel_prev_q <= write_sel;
      end
   end

   // ==========================================================
   // Internal oscillator
   // A tied-low external clock never gives an edge, so the internal tick alone steps
   logic [8:0] osc_cnt_q;
   logic [8:0] osc_last;
   logic       osc_tick;
   logic       step;

   assign osc_last = sync2_q[SY_FRQ] ? 9'(OSC_NORMAL_CYC - 1) : 9'(OSC_FAST_CYC - 1);
   assign osc_tick = (osc_cnt_q >= osc_last);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         osc_cnt_q <= '0;
      end else if (osc_tick || sample_active) begin
         // Held while sampling so the first step waits a full period for the comparator
         osc_cnt_q <= '0;
      end else begin
         osc_cnt_q <= osc_cnt_q + 1'b1;
      end
   end

   assign step = osc_tick || xck_rise;

   // ==========================================================
   // Conversion sequencer
   sahi_state_t      state_q;
   logic [9:0]       samp_cnt_q;
   logic [RW-1:0]    code_q;
   logic [RW-1:0]    bit_q;
   logic             start;
   logic             busy;

   sahi_fifo_if #(.W(RW)) res_if ();

   // Back-pressure: a full result queue refuses the start
   assign start         = write_sel && !wsel_prev_q && (state_q == SAHI_IDLE)
                          && res_if.wready;
   assign busy          = (state_q != SAHI_IDLE);
   assign dac_code      = code_q;
   assign sample_active = (state_q == SAHI_SAMPLE);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         start_refused <= 1'b0;
      end else begin
         start_refused <= write_sel && !wsel_prev_q && !start;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q    <= SAHI_IDLE;
         samp_cnt_q <= '0;
         code_q     <= RESULT_RST;
         bit_q      <= '0;
      end else begin
         case (state_q)
            SAHI_IDLE: begin
               if (start) begin
                  state_q    <= SAHI_SAMPLE;
                  samp_cnt_q <= '0;
               end
            end
            SAHI_SAMPLE: begin
               if (samp_cnt_q == 10'(SAMPLE_CYC - 1)) begin
                  state_q <= SAHI_CONVERT;
                  code_q  <= MSB_ONLY;
                  bit_q   <= MSB_ONLY;
               end else begin
                  samp_cnt_q <= samp_cnt_q + 1'b1;
               end
            end
            SAHI_CONVERT: begin
               if (step) begin
                  // Keep the trial bit when input is above, then try the next
                  code_q <= (sync2_q[SY_CMP] ? code_q : (code_q & ~bit_q)) | (bit_q >> 1);
                  bit_q  <= bit_q >> 1;
                  if (bit_q[0]) begin
                     state_q <= SAHI_STORE;
                  end
               end
            end
            SAHI_STORE: begin
               state_q <= SAHI_IDLE;
            end
            default: begin
               state_q <= SAHI_IDLE;
            end
         endcase
      end
   end

   assign res_if.wdata  = code_q;
   assign res_if.wvalid = (state_q == SAHI_STORE);

   sahi_fifo #(.W(RW), .DEPTH(DEPTH)) u_fifo (
      .clk   (clk),
      .rst_n (rst_n),
      .f     (res_if)
   );

   // ==========================================================
   // Result register and end-of-conversion flag
   // Loading waits for the parallel read to end so a read never sees a torn word
   logic [RW-1:0] result_q;
   logic          load;

   assign res_if.rready = !read_sel;
   assign load          = res_if.rvalid && res_if.rready;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result_q <= RESULT_RST;
      end else if (load) begin
         result_q <= res_if.rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conversion_done_low <= 1'b1;
      end else if (load) begin
         conversion_done_low <= 1'b0;
      end else if (start) begin
         conversion_done_low <= 1'b1;
      end
   end

   // ==========================================================
   // Parallel read path
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         parallel_result_bus <= RESULT_RST;
         parallel_oe_n       <= OE_ALL_OFF;
      end else if (read_sel) begin
         parallel_result_bus <= sahi_par_word(result_q, sync2_q[SY_WFS],
                                              sync2_q[SY_BHS]);
         parallel_oe_n       <= sahi_par_oe_n(sync2_q[SY_WFS], sync2_q[SY_BHS]);
      end else begin
         parallel_result_bus <= RESULT_RST;
         parallel_oe_n       <= OE_ALL_OFF;
      end
   end

   // ==========================================================
   // Serial path, its own copy, loaded with the same result except when the load meets start or busy
   logic [RW-1:0] shreg_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shreg_q    <= RESULT_RST;
         serial_out <= 1'b0;
      end else if (busy || start) begin
         serial_out <= 1'b0;
      end else if (load) begin
         shreg_q    <= res_if.rdata;
         serial_out <= 1'b1;
      end else if (sck_fall && selected) begin
         serial_out <= shreg_q[RW-1];
         shreg_q    <= {shreg_q[RW-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         serial_oe_n <= 1'b1;
      end else begin
         serial_oe_n <= sync2_q[SY_CSL];
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_sample_end;
      (state_q == SAHI_SAMPLE) && (samp_cnt_q == 10'(SAMPLE_CYC - 1));
   endsequence
   sequence s_hold;
      (state_q == SAHI_CONVERT) && !sample_active;
   endsequence

   property p_word;
      read_sel && sync2_q[SY_WFS] |=> (parallel_oe_n == 10'h000)
         && (parallel_result_bus == $past(result_q));
   endproperty
   a_word: assert property (p_word) else $error("word read wrong");

   property p_high_byte;
      read_sel && !sync2_q[SY_WFS] && !sync2_q[SY_BHS] |=>
         (parallel_result_bus[9:2] == $past(result_q[9:2])) && (parallel_oe_n == 10'h003);
   endproperty
   a_high_byte: assert property (p_high_byte) else $error("high byte wrong");

   property p_low_byte;
      read_sel && !sync2_q[SY_WFS] && sync2_q[SY_BHS] |=>
         (parallel_result_bus[7:2] == 6'h00)
         && (parallel_result_bus[1:0] == $past(result_q[1:0]));
   endproperty
   a_low_byte: assert property (p_low_byte) else $error("low byte wrong");

   property p_release;
      !selected |=> (parallel_oe_n == OE_ALL_OFF);
   endproperty
   a_release: assert property (p_release) else $error("bus driven unselected");

   property p_start;
      start |=> (state_q == SAHI_SAMPLE) && conversion_done_low;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_sample_len;
      s_sample_end |=> s_hold;
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("sample end wrong");

   property p_no_early_hold;
      $rose(state_q == SAHI_CONVERT) |-> $past(samp_cnt_q) == 10'(SAMPLE_CYC - 1);
   endproperty
   a_no_early_hold: assert property (p_no_early_hold) else $error("hold too early");

   property p_float;
      sync2_q[SY_CSL] |=> serial_oe_n;
   endproperty
   a_float: assert property (p_float) else $error("serial driven deselected");

   property p_busy_low;
      busy |=> !serial_out;
   endproperty
   a_busy_low: assert property (p_busy_low) else $error("serial high converting");

   property p_done;
      load |=> serial_out && !conversion_done_low;
   endproperty
   a_done: assert property (p_done) else $error("done not flagged");

   property p_shift;
      sck_fall && selected && !busy && !start && !load |=>
         serial_out == $past(shreg_q[RW-1]);
   endproperty
   a_shift: assert property (p_shift) else $error("serial bit wrong");

   property p_hold_result;
      !load |=> $stable(result_q);
   endproperty
   a_hold_result: assert property (p_hold_result) else $error("result changed");
endmodule
`default_nettype wire

/* test/sahi_analog_model.sv */
// Analog front model: input voltage compared against the converter's trial code
`timescale 1ns/1ps
`default_nettype none
module sahi_analog_model
   import sahi_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [RES_W-1:0] vin,
   input  wire logic [RES_W-1:0] dac_code,
   output var  logic             comparator_above
);
   // ==========================================================
   // Comparator
   // One flop of decision delay, as a real comparator settles late
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         comparator_above <= 1'b0;
      end else begin
         comparator_above <= (vin >= dac_code);
      end
   end
endmodule
`default_nettype wire

/* test/tb_sahi_top.sv */
// Self-checking bench of the converter host interface
`timescale 1ns/1ps
`default_nettype none
module tb_sahi_top;
   import sahi_pkg::*;
   // ==========================================================
   // Signals
   logic             clk                  = 1'b0;
   logic             rst_n                = 1'b0;
   logic             word_format_select   = 1'b1;
   logic             byte_half_select     = 1'b0;
   logic             chip_select_low      = 1'b1;
   logic             chip_enable          = 1'b0;
   logic             read_convert_select  = 1'b1;
   logic             ext_conversion_clock = 1'b0; // Unused, so grounded
   logic             freq_ctrl            = 1'b0;
   logic             shift_clock          = 1'b0; // Low outside frames
   logic [RES_W-1:0] vin                  = 10'h2a5;
   logic             comparator_above;
   logic [RES_W-1:0] dac_code;
   logic             sample_active;
   logic [RES_W-1:0] parallel_result_bus;
   logic [RES_W-1:0] parallel_oe_n;
   logic             serial_out;
   logic             serial_oe_n;
   logic             conversion_done_low;
   logic             start_refused;
   int               n_mismatch = 0;
   int               n_compared = 0;
   int               cyc        = 0;
   int               n_refused  = 0;
   int               n_sample   = 0;
   int               t0;
   int               s0;
   int               t_fast;
   int               t_norm;
   logic [RES_W-1:0] exp_a;

   always #5 clk = ~clk;

   sahi_top sahi_top_inst (
      .clk                  (clk),
      .rst_n                (rst_n),
      .word_format_select   (word_format_select),
      .byte_half_select     (byte_half_select),
      .chip_select_low      (chip_select_low),
      .chip_enable          (chip_enable),
      .read_convert_select  (read_convert_select),
      .ext_conversion_clock (ext_conversion_clock),
      .freq_ctrl            (freq_ctrl),
      .shift_clock          (shift_clock),
      .comparator_above     (comparator_above),
      .dac_code             (dac_code),
      .sample_active        (sample_active),
      .parallel_result_bus  (parallel_result_bus),
      .parallel_oe_n        (parallel_oe_n),
      .serial_out           (serial_out),
      .serial_oe_n          (serial_oe_n),
      .conversion_done_low  (conversion_done_low),
      .start_refused        (start_refused)
   );

   sahi_analog_model sahi_analog_model_inst (
      .clk              (clk),
      .rst_n            (rst_n),
      .vin              (vin),
      .dac_code         (dac_code),
      .comparator_above (comparator_above)
   );

   // ==========================================================
   // Monitors
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (start_refused === 1'b1) begin
         n_refused <= n_refused + 1;
      end
      if (sample_active === 1'b1) begin
         n_sample <= n_sample + 1;
      end
   end

   // ==========================================================
   // Tasks
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp,
                      input string what);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic chk1(input logic seen, input logic exp, input string what);
      chk({9'h000, seen}, {9'h000, exp}, what);
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic pins(input logic csl, input logic ce, input logic rdc);
      @(negedge clk);
      chip_select_low     = csl;
      chip_enable         = ce;
      read_convert_select = rdc;
   endtask

   // Write access pulse, then park selected-but-disabled so serial output stays driven
   task automatic start_conv(output int ts, output int ss);
      pins(1'b0, 1'b1, 1'b0);
      ts = cyc;
      ss = n_sample;
      idle(4);
      pins(1'b0, 1'b0, 1'b1);
      idle(4);
      chk1(conversion_done_low, 1'b1, "flag during conversion");
      chk1(serial_out, 1'b0, "serial low while converting");
      chk1(serial_oe_n, 1'b0, "serial driven while selected");
   endtask

   task automatic wait_done(input int ts, output int t);
      for (int i = 0; i < 8000 && conversion_done_low !== 1'b0; i++) begin
         @(negedge clk);
      end
      t = cyc - ts;
      chk1(conversion_done_low, 1'b0, "end of conversion flag");
      chk1(serial_out, 1'b1, "serial high at end");
   endtask

   task automatic read_par(input logic wfs, input logic bhs, input logic [RES_W-1:0] eb,
                           input logic [RES_W-1:0] eo);
      @(negedge clk);
      word_format_select = wfs;
      byte_half_select   = bhs;
      pins(1'b0, 1'b1, 1'b1);
      idle(6);
      chk(parallel_result_bus, eb, "parallel data");
      chk(parallel_oe_n, eo, "parallel enables");
   endtask

   // Ten bits at a 160 ns shift period, with a word read held open meanwhile
   task automatic shift_out(input logic [RES_W-1:0] exp);
      word_format_select = 1'b1;
      pins(1'b0, 1'b1, 1'b1);
      for (int i = 0; i < RES_W; i++) begin
         shift_clock = 1'b1;
         idle(8);
         shift_clock = 1'b0;
         idle(8);
         chk1(serial_out, exp[RES_W-1-i], "serial bit");
      end
      chk(parallel_result_bus, exp, "parallel during shift");
      pins(1'b0, 1'b0, 1'b1);
   endtask

   // ==========================================================
   // Watchdog: the run needs about 8300 cycles
   initial begin
      #500_000;
      n_mismatch++;
      complete_run();
   end

   // ==========================================================
   // Tests
   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      idle(2);
      chk(parallel_oe_n, OE_ALL_OFF, "bus released after reset");
      chk1(serial_oe_n, 1'b1, "serial released after reset");
      chk1(conversion_done_low, 1'b1, "flag after reset");
      pins(1'b0, 1'b0, 1'b1);
      exp_a = vin;
      start_conv(t0, s0);
      pins(1'b0, 1'b1, 1'b0);
      idle(6);
      pins(1'b0, 1'b0, 1'b1);
      idle(4);
      chk1(n_refused == 1, 1'b1, "start while busy refused");
      wait_done(t0, t_fast);
      chk1(t_fast <= MIN_CONV_CYC, 1'b1, "fast conversion rate");
      chk(dac_code, exp_a, "final trial code");
      chk1((n_sample - s0) == SAMPLE_CYC, 1'b1, "sample phase length");
      read_par(1'b1, 1'b0, exp_a, 10'h000);
      read_par(1'b0, 1'b0, {exp_a[9:2], 2'b00}, 10'h003);
      read_par(1'b0, 1'b1, {8'h00, exp_a[1:0]}, 10'h300);
      pins(1'b0, 1'b0, 1'b1);
      idle(6);
      chk(parallel_oe_n, OE_ALL_OFF, "released with enable low");
      pins(1'b1, 1'b1, 1'b1);
      idle(6);
      chk(parallel_oe_n, OE_ALL_OFF, "released when deselected");
      chk1(serial_oe_n, 1'b1, "serial floats when deselected");
      pins(1'b0, 1'b0, 1'b1);
      idle(6);
      shift_out(exp_a);
      // Input moves without a new start: the held result must not follow
      vin = 10'h15a;
      idle(50);
      read_par(1'b1, 1'b0, exp_a, 10'h000);
      pins(1'b0, 1'b0, 1'b0);
      idle(10);
      chk1(conversion_done_low, 1'b0, "no start with enable low");
      pins(1'b1, 1'b1, 1'b0);
      idle(10);
      chk1(conversion_done_low, 1'b0, "no start when deselected");
      pins(1'b0, 1'b0, 1'b1);
      freq_ctrl = 1'b1;
      start_conv(t0, s0);
      wait_done(t0, t_norm);
      chk1((t_norm - t_fast) >= 1600 && (t_norm - t_fast) <= 2400, 1'b1, "osc rate");
      read_par(1'b1, 1'b0, 10'h15a, 10'h000);
      pins(1'b0, 1'b0, 1'b1);
      complete_run();
   end
endmodule
`default_nettype wire
